// file: rtl/cacc_top.sv
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "cacc_defines.svh"

module cacc_top (
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        SYS_RST,
  // avalon-mm slave
  input  wire logic [11:0] AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output      logic [31:0] AVS_READDATA,
  output      logic        AVS_WAITREQUEST,
  // module pins, split into input, output and enable
  input  wire logic [2:0]  MODULE_PIN_I,
  output      logic [2:0]  MODULE_PIN_O,
  output      logic [2:0]  MODULE_PIN_OE,
  // interrupt request
  output      logic        IRQ
);

  // =====================================================================
  // bus handshake

  logic        waitreq_r;
  logic [31:0] rdata_r;
  logic        req;
  logic        acc_done;
  logic        wr_en;
  logic [9:0]  idx;

  // every access takes one wait state, so read data can be registered
  assign req      = AVS_READ | AVS_WRITE;
  assign acc_done = req & ~waitreq_r;
  assign wr_en    = AVS_WRITE & acc_done;
  assign idx      = AVS_ADDRESS[11:2];

  // waitrequest drops for exactly one cycle per request
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      waitreq_r <= 1'b1;
    end else begin
      waitreq_r <= ~(req & waitreq_r);
    end
  end

  // =====================================================================
  // register write strobes

  logic wr_ctrl;
  logic wr_cnt;
  logic wr_ien;
  logic wr_iclr;
  logic [2:0] wr_mode;
  logic [2:0] wr_ccr;

  assign wr_ctrl    = wr_en & (idx == `CACC_IDX_CTRL);
  assign wr_cnt     = wr_en & (idx == `CACC_IDX_CNT);
  assign wr_ien     = wr_en & (idx == `CACC_IDX_IEN);
  assign wr_iclr    = wr_en & (idx == `CACC_IDX_ICLR);
  assign wr_mode[0] = wr_en & (idx == `CACC_IDX_MODE0);
  assign wr_mode[1] = wr_en & (idx == `CACC_IDX_MODE1);
  assign wr_mode[2] = wr_en & (idx == `CACC_IDX_MODE2);
  assign wr_ccr[0]  = wr_en & (idx == `CACC_IDX_CCR0);
  assign wr_ccr[1]  = wr_en & (idx == `CACC_IDX_CCR1);
  assign wr_ccr[2]  = wr_en & (idx == `CACC_IDX_CCR2);

  // =====================================================================
  // mode registers, one per module

  logic [7:0] mode0_r;
  logic [7:0] mode1_r;
  logic [7:0] mode2_r;
  logic [7:0] mode_w [0:2];

  // each module keeps its own mode byte
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      mode0_r <= `CACC_RST_BYTE;
      mode1_r <= `CACC_RST_BYTE;
      mode2_r <= `CACC_RST_BYTE;
    end else begin
      if (wr_mode[0]) mode0_r <= AVS_WRITEDATA[7:0];  // RULE_01
      if (wr_mode[1]) mode1_r <= AVS_WRITEDATA[7:0];
      if (wr_mode[2]) mode2_r <= AVS_WRITEDATA[7:0];
    end
  end

  assign mode_w[0] = mode0_r;
  assign mode_w[1] = mode1_r;
  assign mode_w[2] = mode2_r;

  // =====================================================================
  // shared counter

  logic        run_r;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        cnt_wrap;
  logic        lo_wrap;

  // compares only fire on a counting cycle, so a stopped counter
  // sitting on a match does not keep toggling or flagging
  assign cnt_wrap = run_r & (cnt_r == `CACC_CNT_MAX);  // RULE_12
  assign lo_wrap  = run_r & (cnt_r[7:0] == `CACC_LO_MAX);
  assign cnt_nxt  = wr_cnt ? AVS_WRITEDATA[15:0] :
                    run_r  ? cnt_r + 16'h0001 : cnt_r;  // RULE_12

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      cnt_r <= `CACC_RST_WORD;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // =====================================================================
  // mode decode

  // capture needs every compare bit clear; each compare mode also needs
  // the comparator enable, so a half-set mode byte stays idle and never
  // starts driving the pin by accident
  function automatic cacc_pkg::cacc_mode_t cacc_mode_f(input logic [7:0] m);
    cacc_pkg::cacc_mode_t r;
    r = cacc_pkg::MODE_IDLE;
    if (!m[`CACC_BIT_MAT] && !m[`CACC_BIT_TOG] && !m[`CACC_BIT_PWM] &&
        (m[`CACC_BIT_CAPP] || m[`CACC_BIT_CAPN])) begin
      r = cacc_pkg::MODE_CAPTURE;  // RULE_04
    end else if (m[`CACC_BIT_ECOM]) begin  // RULE_05
      if (m[`CACC_BIT_PWM] && m[`CACC_BIT_TOG]) begin
        r = cacc_pkg::MODE_FREQ;  // RULE_08
      end else if (m[`CACC_BIT_PWM]) begin
        r = m[`CACC_BIT_PWM16] ? cacc_pkg::MODE_PWM16 : cacc_pkg::MODE_PWM8;  // RULE_09
      end else if (m[`CACC_BIT_MAT] && m[`CACC_BIT_TOG]) begin
        r = cacc_pkg::MODE_HSO;  // RULE_07
      end else if (m[`CACC_BIT_MAT]) begin
        r = cacc_pkg::MODE_TIMER;  // RULE_06
      end
    end
    return r;
  endfunction

  // =====================================================================
  // per-module capture, compare and pin logic

  logic [15:0] ccr_w [0:2];
  logic [2:0]  flag_set;
  logic [2:0]  pin_q;
  logic [2:0]  oe_q;
  logic [2:0]  eccf;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_mod
      cacc_pkg::cacc_mode_t mode;
      logic [7:0]  m;
      logic [15:0] ccr_r;
      logic [15:0] ccr_nxt;
      logic        pin_r;
      logic        pin_nxt;
      logic        oe_r;
      logic        pin_d_r;
      logic        rise;
      logic        fall;
      logic        cap;
      logic        eq16;
      logic        eq8;
      logic        hit;
      logic        flip;
      logic        ftog;
      logic        oe_nxt;

      assign m    = mode_w[gi];
      assign mode = cacc_mode_f(m);  // RULE_01

      // edge detect on the synchronous pin input
      assign rise = MODULE_PIN_I[gi] & ~pin_d_r;
      assign fall = ~MODULE_PIN_I[gi] & pin_d_r;
      assign cap  = (mode == cacc_pkg::MODE_CAPTURE) &
                    ((m[`CACC_BIT_CAPP] & rise) |  // RULE_02 RULE_04
                     (m[`CACC_BIT_CAPN] & fall));  // RULE_03 RULE_04

      // compare terms, all gated by run; hit, flip and ftog also by the comparator enable
      assign eq16 = run_r & (cnt_r == ccr_r);
      assign eq8  = run_r & (cnt_r[7:0] == ccr_r[7:0]);
      assign hit  = m[`CACC_BIT_ECOM] & m[`CACC_BIT_MAT] & eq16;  // RULE_05 RULE_06
      assign flip = (mode == cacc_pkg::MODE_HSO) & eq16;  // RULE_07
      assign ftog = (mode == cacc_pkg::MODE_FREQ) & eq8;  // RULE_08

      assign flag_set[gi] = cap | hit;  // RULE_13 RULE_06
      assign eccf[gi]     = m[`CACC_BIT_ECCF];

      // register update: capture wins over a bus write in the same cycle,
      // frequency mode advances the low byte by the high byte on each toggle,
      // 8-bit modulation reloads the low byte from the high byte at wrap
      always_comb begin
        ccr_nxt = ccr_r;
        if (cap) begin
          ccr_nxt = cnt_r;  // RULE_13
        end else if (wr_ccr[gi]) begin
          ccr_nxt = AVS_WRITEDATA[15:0];
        end else if (ftog) begin
          ccr_nxt[7:0] = ccr_r[7:0] + ccr_r[15:8];  // RULE_08
        end else if ((mode == cacc_pkg::MODE_PWM8) & lo_wrap) begin
          ccr_nxt[7:0] = ccr_r[15:8];  // RULE_09
        end
      end

      // pin level per mode
      always_comb begin
        pin_nxt = pin_r;
        oe_nxt  = 1'b0;
        unique case (mode)
          cacc_pkg::MODE_IDLE,
          cacc_pkg::MODE_CAPTURE,
          cacc_pkg::MODE_TIMER: begin
            pin_nxt = pin_r;
          end
          cacc_pkg::MODE_HSO: begin
            oe_nxt  = 1'b1;
            pin_nxt = flip ? ~pin_r : pin_r;  // RULE_07
          end
          cacc_pkg::MODE_FREQ: begin
            oe_nxt  = 1'b1;
            pin_nxt = ftog ? ~pin_r : pin_r;  // RULE_08
          end
          cacc_pkg::MODE_PWM8: begin
            oe_nxt  = 1'b1;
            pin_nxt = cnt_r[7:0] >= ccr_r[7:0];  // RULE_09
          end
          cacc_pkg::MODE_PWM16: begin
            oe_nxt  = 1'b1;
            pin_nxt = cnt_r >= ccr_r;  // RULE_09
          end
        endcase
      end

      always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
          ccr_r   <= `CACC_RST_WORD;
          pin_r   <= 1'b0;
          oe_r    <= 1'b0;
          pin_d_r <= 1'b0;
        end else begin
          ccr_r   <= ccr_nxt;
          pin_r   <= pin_nxt;
          oe_r    <= oe_nxt;
          pin_d_r <= MODULE_PIN_I[gi];
        end
      end

      assign ccr_w[gi] = ccr_r;
      assign pin_q[gi] = pin_r;
      assign oe_q[gi]  = oe_r;
    end
  endgenerate

  // =====================================================================
  // control flags: hardware set wins over any software clear

  logic       cf_r;
  logic [2:0] ccf_r;
  logic       cf_nxt;
  logic [2:0] ccf_nxt;
  logic       cf_sw;
  logic [2:0] ccf_sw;

  // software value: plain write on control, write-one-to-clear on clear
  assign cf_sw  = (wr_ctrl ? AVS_WRITEDATA[`CACC_BIT_CF] : cf_r) &
                  ~(wr_iclr & AVS_WRITEDATA[`CACC_BIT_CF]);
  assign ccf_sw = (wr_ctrl ? AVS_WRITEDATA[2:0] : ccf_r) &
                  ~({3{wr_iclr}} & AVS_WRITEDATA[2:0]);
  assign cf_nxt  = cnt_wrap | cf_sw;  // RULE_12
  assign ccf_nxt = flag_set | ccf_sw;  // RULE_13

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      cf_r  <= 1'b0;
      ccf_r <= `CACC_RST_MOD;
      run_r <= 1'b0;
    end else begin
      cf_r  <= cf_nxt;
      ccf_r <= ccf_nxt;
      if (wr_ctrl) run_r <= AVS_WRITEDATA[`CACC_BIT_CR];  // RULE_12
    end
  end

  // =====================================================================
  // interrupt: enable register gates status, module bits also need
  // their own flag interrupt enable; the processor gates stay outside

  logic [7:0] ien_r;
  logic [7:0] stat_w;
  logic [7:0] mask_w;
  logic       irq_r;

  assign stat_w = {cf_r, 1'b0, 3'h0, ccf_r};
  assign mask_w = {ien_r[`CACC_BIT_CF], 4'h0, ien_r[2:0] & eccf};  // RULE_10

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      ien_r <= `CACC_RST_BYTE;
      irq_r <= 1'b0;
    end else begin
      if (wr_ien) ien_r <= AVS_WRITEDATA[7:0];
      irq_r <= |(stat_w & mask_w);  // RULE_10
    end
  end

  // =====================================================================
  // read mux; unmapped and write-only addresses read zero

  logic [31:0] rd_word;
  logic [7:0]  ctrl_w;

  assign ctrl_w  = {cf_r, run_r, 3'h0, ccf_r};
  assign rd_word = (idx == `CACC_IDX_CTRL)  ? {`CACC_PAD24, ctrl_w} :
                   (idx == `CACC_IDX_MODE0) ? {`CACC_PAD24, mode0_r} :
                   (idx == `CACC_IDX_MODE1) ? {`CACC_PAD24, mode1_r} :
                   (idx == `CACC_IDX_MODE2) ? {`CACC_PAD24, mode2_r} :
                   (idx == `CACC_IDX_CNT)   ? {`CACC_PAD16, cnt_r} :
                   (idx == `CACC_IDX_CCR0)  ? {`CACC_PAD16, ccr_w[0]} :
                   (idx == `CACC_IDX_CCR1)  ? {`CACC_PAD16, ccr_w[1]} :
                   (idx == `CACC_IDX_CCR2)  ? {`CACC_PAD16, ccr_w[2]} :
                   (idx == `CACC_IDX_ISTAT) ? {`CACC_PAD24, stat_w} :
                   (idx == `CACC_IDX_IEN)   ? {`CACC_PAD24, ien_r} :
                   32'h0000_0000;

  // sampled in the wait cycle so data stands when waitrequest drops
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      rdata_r <= 32'h0000_0000;
    end else if (AVS_READ & waitreq_r) begin
      rdata_r <= rd_word;
    end
  end

  // =====================================================================
  // outputs straight from flops

  assign AVS_READDATA    = rdata_r;
  assign AVS_WAITREQUEST = waitreq_r;
  assign MODULE_PIN_O    = pin_q;
  assign MODULE_PIN_OE   = oe_q;
  assign IRQ             = irq_r;

endmodule

// file: rtl/cacc_defines.svh
// What this block does
// RULE_01: each of the three modules picks its own mode, whatever the other modules do.
// RULE_02: with rising capture enabled, a rising edge on the module pin captures the counter.
// RULE_03: with falling capture enabled, a falling edge on the module pin captures the counter.
// RULE_04: with both capture enables and no compare mode bit set, every pin transition captures.
// RULE_05: the comparator enable gates all compare modes of a module.
// RULE_06: with match enabled, counter equal to the compare register sets the module flag.
// RULE_07: with toggle enabled, each match inverts the module pin.
// RULE_08: toggle plus pulse mode gives a frequency output on the pin.
// RULE_09: pulse mode without toggle gives 8-bit or 16-bit modulation, chosen by the width select.
// RULE_10: the flag interrupt enable masks the module flag onto the interrupt request.
// RULE_11: software must open the global and array interrupt gates before a request is seen; the block has none, IRQ follows the enabled flags.
// RULE_12: the counter only counts while run is set and sets the overflow flag on wrap.
// RULE_13: a capture copies the counter into the module register and sets its flag.
`ifndef CACC_DEFINES_SVH
`define CACC_DEFINES_SVH

// =====================================================================
// register indices (byte address is four times the index)
`define CACC_IDX_CTRL     10'h0D8
`define CACC_IDX_MODE0    10'h0DA
`define CACC_IDX_MODE1    10'h0DB
`define CACC_IDX_MODE2    10'h0DC
`define CACC_IDX_CNT      10'h0E0
`define CACC_IDX_CCR0     10'h0E4
`define CACC_IDX_CCR1     10'h0E5
`define CACC_IDX_CCR2     10'h0E6
`define CACC_IDX_ISTAT    10'h0F0
`define CACC_IDX_IEN      10'h0F1
`define CACC_IDX_ICLR     10'h0F2

// =====================================================================
// mode register fields
`define CACC_BIT_PWM16    7
`define CACC_BIT_ECOM     6
`define CACC_BIT_CAPP     5
`define CACC_BIT_CAPN     4
`define CACC_BIT_MAT      3
`define CACC_BIT_TOG      2
`define CACC_BIT_PWM      1
`define CACC_BIT_ECCF     0

// =====================================================================
// control register fields and reset values
`define CACC_BIT_CF       7
`define CACC_BIT_CR       6
`define CACC_RST_BYTE     8'h00
`define CACC_RST_WORD     16'h0000
`define CACC_RST_MOD      3'h0
`define CACC_CNT_MAX      16'hFFFF
`define CACC_LO_MAX       8'hFF
`define CACC_PAD16        16'h0000
`define CACC_PAD24        24'h00_0000

`endif

// file: rtl/cacc_pkg.sv
`include "cacc_defines.svh"

package cacc_pkg;

  // =====================================================================
  // operating modes of one module
  typedef enum logic [2:0] {
    MODE_IDLE,
    MODE_CAPTURE,
    MODE_TIMER,
    MODE_HSO,
    MODE_FREQ,
    MODE_PWM8,
    MODE_PWM16
  } cacc_mode_t;

endpackage

// file: tb/cacc_asserts.sv
`timescale 1ns/1ps
module cacc_asserts (
  // clock and reset
  input wire logic        MCLK,
  input wire logic        SYS_RST,
  // register bus
  input wire logic [11:0] AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  // pins and interrupt
  input wire logic [2:0]  MODULE_PIN_I,
  input wire logic [2:0]  MODULE_PIN_O,
  input wire logic [2:0]  MODULE_PIN_OE,
  input wire logic        IRQ
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  // a finished write is the only thing software does to clear or re-mode
  wire wr_done = AVS_WRITE && !AVS_WAITREQUEST;
  // =====================================================================
  // bus handshake
  property p_wait_answer;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("no answer after request");
  property p_wait_single;
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST;
  endproperty
  a_wait_single: assert property (p_wait_single) else $error("wait low too long");
  property p_wait_cause;
    !AVS_WAITREQUEST |-> $past(AVS_READ || AVS_WRITE);
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
  property p_rdata_upper;
    AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[31:16] == 16'h0000;
  endproperty
  a_rdata_upper: assert property (p_rdata_upper) else $error("read data upper bits set");
  property p_rdata_hold;
    $changed(AVS_READDATA) |-> $past(AVS_READ);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  // =====================================================================
  // flags, enables and undriven pins only move back on software's word
  property p_irq_fall;
    $fell(IRQ) |-> $past(wr_done) || $past(wr_done, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped by itself");
  property p_oe_cause;
    $changed(MODULE_PIN_OE) |-> $past(wr_done) || $past(wr_done, 2);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("pin enable moved");
  property p_pin_driven;
    $changed(MODULE_PIN_O) && !$past(wr_done) && !$past(wr_done, 2) |->
      ((MODULE_PIN_O ^ $past(MODULE_PIN_O)) & ~MODULE_PIN_OE) == 3'b000;
  endproperty
  a_pin_driven: assert property (p_pin_driven) else $error("undriven pin moved");
endmodule

bind cacc_top cacc_asserts u_chk (.MCLK, .SYS_RST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
  .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST, .MODULE_PIN_I, .MODULE_PIN_O,
  .MODULE_PIN_OE, .IRQ);

// file: tb/cacc_pin_model.sv
`timescale 1ns/1ps
module cacc_pin_model (
  // from the block
  input  wire logic [2:0] pin_o,
  input  wire logic [2:0] pin_oe,
  // external source level and resolved pin
  input  wire logic [2:0] ext_lvl,
  output      logic [2:0] pin_lvl
);
  // the block wins while it drives; the outside source only shows when released
  assign pin_lvl = (pin_oe & pin_o) | (~pin_oe & ext_lvl);
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
`include "cacc_defines.svh"
module tb_top;
  // =====================================================================
  // stimulus and observed signals
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] adr = 12'h000;
  logic        rd_en = 1'b0;
  logic        wr_en = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        wait_rq;
  logic [2:0]  ext = 3'h0;
  logic [2:0]  pin_lvl;
  logic [2:0]  pin_o;
  logic [2:0]  pin_oe;
  logic        irq;
  int          num_errors = 0;
  int          tests_run = 0;
  logic [7:0]  cap_mode [3] = '{8'h20, 8'h10, 8'h30};
  logic [15:0] cap_exp [3] = '{16'h0111, 16'h0222, 16'h0222};
  logic [15:0] cap_mid [3] = '{16'h0111, 16'h0000, 16'h0111};
  // processor-side interrupt gates, opened by software before irqs count
  logic        glb_gate = 1'b0;
  logic        arr_gate = 1'b0;
  logic [7:0]  pw_mode [2] = '{8'h42, 8'hC2};
  logic [15:0] pw_ccr [2] = '{16'h8080, 16'h8000};
  logic [15:0] pw_cnt [2] = '{16'h0000, 16'h7F80};
  localparam logic [11:0] AD_CTRL = {`CACC_IDX_CTRL, 2'b00}, AD_M0 = {`CACC_IDX_MODE0, 2'b00};
  localparam logic [11:0] AD_M1 = {`CACC_IDX_MODE1, 2'b00}, AD_M2 = {`CACC_IDX_MODE2, 2'b00};
  localparam logic [11:0] AD_CNT = {`CACC_IDX_CNT, 2'b00}, AD_C0 = {`CACC_IDX_CCR0, 2'b00};
  localparam logic [11:0] AD_C1 = {`CACC_IDX_CCR1, 2'b00}, AD_C2 = {`CACC_IDX_CCR2, 2'b00};
  localparam logic [11:0] AD_IST = {`CACC_IDX_ISTAT, 2'b00}, AD_IEN = {`CACC_IDX_IEN, 2'b00};
  localparam logic [11:0] AD_ICLR = {`CACC_IDX_ICLR, 2'b00};
  always #4 clk = ~clk;
  // =====================================================================
  // design and the outside world on its pins
  cacc_top dut (.MCLK(clk), .SYS_RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd_en),
    .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_rq),
    .MODULE_PIN_I(pin_lvl), .MODULE_PIN_O(pin_o), .MODULE_PIN_OE(pin_oe), .IRQ(irq));
  cacc_pin_model u_pins (.pin_o(pin_o), .pin_oe(pin_oe), .ext_lvl(ext), .pin_lvl(pin_lvl));
  // =====================================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one bus cycle; request held until the edge that sees wait low
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    wr_en <= w;
    rd_en <= !w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (wait_rq !== 1'b0) @(posedge clk);
    q = rdat;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // counts high cycles and level changes of one driven pin
  task automatic watch(input int n, input int p, output int hi, output int tg);
    logic pv;
    hi = 0;
    tg = 0;
    pv = pin_o[p];
    repeat (n) begin
      @(posedge clk);
      if (pin_o[p] !== pv) tg++;
      if (pin_o[p] === 1'b1) hi++;
      pv = pin_o[p];
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // =====================================================================
  // watchdog: the whole sequence needs roughly 1300 cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
  // =====================================================================
  // test sequence
  initial begin
    int hi;
    int tg;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(AD_CTRL, 32'h0);
    rd(AD_M0, 32'h0);
    wr(AD_M1, 32'hA5);
    rd(AD_M1, 32'hA5);
    rd(AD_M2, 32'h0);
    rd(AD_ICLR, 32'h0);
    rd(12'h004, 32'h0);
    wr(AD_M1, 32'h0);
    $display("registers done, mismatches %0d", num_errors);
    // wrap and stop
    wr(AD_CNT, 32'hFFF0);
    wr(AD_CTRL, 32'h40);
    repeat (30) @(posedge clk);
    rd(AD_CTRL, 32'hC0);
    rd(AD_IST, 32'h80);
    wr(AD_ICLR, 32'h80);
    rd(AD_CTRL, 32'h40);
    wr(AD_CTRL, 32'h0);
    wr(AD_CNT, 32'h1234);
    repeat (10) @(posedge clk);
    rd(AD_CNT, 32'h1234);
    rd(AD_CTRL, 32'h0);
    $display("counter done, mismatches %0d", num_errors);
    // edge capture on a stopped counter; value before and after each edge differs
    for (int i = 0; i < 3; i++) begin
      wr(AD_C0, 32'h0);
      wr(AD_CTRL, 32'h0);
      wr(AD_M0, {24'h0, cap_mode[i]});
      wr(AD_CNT, 32'h0111);
      ext[0] <= 1'b1;
      repeat (4) @(posedge clk);
      rd(AD_C0, {16'h0, cap_mid[i]});
      wr(AD_CNT, 32'h0222);
      ext[0] <= 1'b0;
      repeat (4) @(posedge clk);
      rd(AD_C0, {16'h0, cap_exp[i]});
      rd(AD_CTRL, 32'h1);
    end
    wr(AD_M0, 32'h0);
    $display("capture done, mismatches %0d", num_errors);
    // match without then with comparator enable, then masking and clearing
    glb_gate <= 1'b1;
    arr_gate <= 1'b1;
    wr(AD_C1, 32'h0050);
    wr(AD_IEN, 32'h02);
    for (int i = 0; i < 2; i++) begin
      wr(AD_CTRL, 32'h0);
      wr(AD_M1, i ? 32'h49 : 32'h09);
      wr(AD_CNT, 32'h0);
      wr(AD_CTRL, 32'h40);
      repeat (120) @(posedge clk);
      rd(AD_CTRL, i ? 32'h42 : 32'h40);
      chk({31'h0, irq & glb_gate & arr_gate}, i);
    end
    wr(AD_M1, 32'h48);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(AD_M1, 32'h49);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    rd(AD_IST, 32'h02);
    wr(AD_ICLR, 32'h02);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rd(AD_IST, 32'h0);
    wr(AD_M1, 32'h0);
    $display("timer done, mismatches %0d", num_errors);
    // high speed output: one match, one toggle
    wr(AD_CTRL, 32'h0);
    wr(AD_C2, 32'h0010);
    wr(AD_M2, 32'h4C);
    wr(AD_CNT, 32'h0);
    wr(AD_CTRL, 32'h40);
    repeat (40) @(posedge clk);
    rd(AD_CTRL, 32'h44);
    chk({29'h0, pin_oe}, 32'h4);
    chk({31'h0, pin_o[2]}, 32'h1);
    // frequency output: step of four counts gives a toggle every four cycles
    wr(AD_C2, 32'h0404);
    wr(AD_M2, 32'h46);
    // restart the counter so the first low-byte match falls inside the window
    wr(AD_CNT, 32'h0);
    watch(200, 2, hi, tg);
    chk({31'h0, tg > 44 && tg < 56}, 32'h1);
    wr(AD_CTRL, 32'h0);
    wr(AD_M2, 32'h0);
    $display("output done, mismatches %0d", num_errors);
    // both modulation widths; only the 8-bit setting is wrong by half under the other width
    for (int i = 0; i < 2; i++) begin
      wr(AD_C0, {16'h0, pw_ccr[i]});
      wr(AD_M0, {24'h0, pw_mode[i]});
      wr(AD_CNT, {16'h0, pw_cnt[i]});
      wr(AD_CTRL, 32'h40);
      watch(256, 0, hi, tg);
      wr(AD_CTRL, 32'h0);
      chk({31'h0, hi > 119 && hi < 141}, 32'h1);
      chk({31'h0, pin_oe[0]}, 32'h1);
    end
    $display("modulation done, mismatches %0d", num_errors);
    print_verdict();
  end
endmodule
